/* File: clock_leg.sv */
`timescale 1ns/10ps
`default_nettype none

module clock_leg
  import clock_mux_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n_in,
  clock_leg_if.leg  lf
);

  typedef struct packed {
    logic       want_m;
    logic       want_s;
    logic       oth_m;
    logic       oth_s;
    logic       frc_m;
    logic       frc_s;
    logic       rst_m;
    logic       rst_s;
    logic       on;
    logic       en;
    logic [1:0] cnt;
  } leg_state_t;

  leg_state_t q;
  leg_state_t d;
  logic       gate_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d        = q;
    d.want_m = lf.want;
    d.want_s = q.want_m;
    d.oth_m  = lf.other_on;
    d.oth_s  = q.oth_m;
    d.frc_m  = lf.force_sw;
    d.frc_s  = q.frc_m;
    d.rst_m  = rst_n_in;
    d.rst_s  = q.rst_m;
    if (!q.rst_s) begin
      d.on  = 1'b0;
      d.en  = 1'b0;
      d.cnt = 2'h0;
    end else if (q.frc_s && !q.want_s) begin
      d.on  = 1'b0;
      d.en  = 1'b0;
      d.cnt = 2'h0;
    end else if (!q.on) begin
      if (q.want_s && (!q.oth_s || q.frc_s)) begin
        d.on  = 1'b1;
        d.cnt = 2'h0;
      end
    end else if (q.en) begin
      if (!q.want_s) begin
        d.en  = 1'b0;
        d.cnt = 2'h0;
      end
    end else if (q.cnt == PARK_LAST) begin
      d.cnt = 2'h0;
      if (q.want_s) begin
        d.en = 1'b1;
      end else begin
        d.on = 1'b0;
      end
    end else begin
      d.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // enable moves only while the clock is low, so only the forced kill below can cut a pulse short
  // glitch-free gating
  always_ff @(negedge clk) begin
    gate_q <= q.rst_s & q.en;
  end

  assign lf.on   = q.on;
  assign lf.en   = q.en;
  // a forced switch kills a possibly dead source without its own edges
  // immediate kill
  assign lf.gate = gate_q & ~(lf.force_sw & ~lf.want);

  ////////////////////////////////////////////////////////////////////////////
  park_old_a: assert property (
    @(posedge clk) disable iff (!q.rst_s)
    $fell(q.en) && !q.frc_s |-> q.on [*3] ##1 (!q.on || q.en))
    else $error("old clock not parked for three cycles");

  arm_new_a: assert property (
    @(posedge clk) disable iff (!q.rst_s)
    $rose(q.on) |-> !q.en [*3] ##1 (q.en || !q.on))
    else $error("new clock not held low for three cycles");

  handoff_a: assert property (
    @(posedge clk) disable iff (!q.rst_s)
    $rose(q.on) |-> !$past(q.oth_s) || $past(q.frc_s))
    else $error("leg armed while other leg still on");

  force_kill_a: assert property (
    @(posedge clk) disable iff (!q.rst_s)
    q.frc_s && !q.want_s |=> !q.on && !q.en)
    else $error("forced switch did not drop leg");

endmodule

`default_nettype wire

/* File: clock_leg_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface clock_leg_if;
  logic want;
  logic force_sw;
  logic other_on;
  logic on;
  logic en;
  logic gate;

  modport leg (
    input  want,
    input  force_sw,
    input  other_on,
    output on,
    output en,
    output gate
  );

  modport top (
    output want,
    output force_sw,
    output other_on,
    input  on,
    input  en,
    input  gate
  );
endinterface

`default_nettype wire

/* File: clock_mux_pkg.sv */
package clock_mux_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;

  // register byte addresses
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  STATUS_OFS   = 8'h04;

  // control field positions
  localparam int          CTRL_SEL     = 0;
  localparam int          CTRL_FORCE   = 1;
  localparam int          CTRL_GATE_N  = 2;
  localparam int          CTRL_LEVEL   = 3;
  localparam int          CTRL_SLEEP_N = 4;
  localparam int          CTRL_W       = 5;
  // source one selected, outputs toggling, awake
  localparam logic [4:0]  CTRL_RESET   = 5'h11;

  // status field positions
  localparam int          STAT_ON1     = 0;
  localparam int          STAT_EN1     = 1;
  localparam int          STAT_ON2     = 2;
  localparam int          STAT_EN2     = 3;
  localparam int          STAT_BUSY    = 4;

  // parking cycles on each side of a changeover
  localparam int          PARK_CYCLES  = 3;
  localparam logic [1:0]  PARK_LAST    = 2'(PARK_CYCLES - 1);

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* File: glitchless_clock_mux_fanout.sv */
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module glitchless_clock_mux_fanout
  import clock_mux_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_a1,
  input  wire logic              clk_a2,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   q1,
  output logic                   q1_n,
  output logic                   q2,
  output logic                   q2_n
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [DATA_W-1:0] w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic [3:0]        leg_m;
    logic [3:0]        leg_s;
  } top_state_t;

  top_state_t        q;
  top_state_t        d;

  clock_leg_if       leg1 ();
  clock_leg_if       leg2 ();

  logic              aw_hs;
  logic              w_hs;
  logic              aw_now;
  logic              w_now;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic [DATA_W-1:0] status_word;
  logic              mux_clk;
  logic              gate_n;
  logic              level;
  logic              sleep_n;

  assign gate_n  = q.ctrl[CTRL_GATE_N];
  assign level   = q.ctrl[CTRL_LEVEL];
  assign sleep_n = q.ctrl[CTRL_SLEEP_N];

  ////////////////////////////////////////////////////////////////////////////
  // source routing
  assign leg1.want     = sleep_n & q.ctrl[CTRL_SEL];
  assign leg2.want     = sleep_n & ~q.ctrl[CTRL_SEL];
  assign leg1.force_sw = q.ctrl[CTRL_FORCE];
  assign leg2.force_sw = q.ctrl[CTRL_FORCE];
  assign leg1.other_on = leg2.on;
  assign leg2.other_on = leg1.on;

  clock_leg u_leg1 (
    .clk      (clk_a1),
    .rst_n_in (aresetn),
    .lf       (leg1.leg)
  );

  clock_leg u_leg2 (
    .clk      (clk_a2),
    .rst_n_in (aresetn),
    .lf       (leg2.leg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // at most one gate is open at a time, so a plain and-or is glitch free
  // glitch-free combine
  assign mux_clk = (clk_a1 & leg1.gate) | (clk_a2 & leg2.gate);

  // gating bypasses the source clocks, so edges of gate_n can cut a pulse
  // asynchronous gate
  always_comb begin
    if (!sleep_n) begin
      q1   = 1'b1;
      q1_n = 1'b1;
    end else if (!gate_n) begin
      q1   = mux_clk;
      q1_n = ~mux_clk;
    end else begin
      q1   = level;
      q1_n = ~level;
    end
    q2   = q1;
    q2_n = q1_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready  = ~q.w_got & ~q.bvalid;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  assign aw_hs   = s_axi_awvalid & s_axi_awready;
  assign w_hs    = s_axi_wvalid & s_axi_wready;
  assign aw_now  = q.aw_got | aw_hs;
  assign w_now   = q.w_got | w_hs;
  assign wr_addr = q.aw_got ? q.aw_addr : s_axi_awaddr;
  assign wr_data = q.w_got ? q.w_data : s_axi_wdata;
  assign wr_strb = q.w_got ? q.w_strb : s_axi_wstrb;

  always_comb begin
    status_word            = '0;
    status_word[STAT_ON1]  = q.leg_s[0];
    status_word[STAT_EN1]  = q.leg_s[1];
    status_word[STAT_ON2]  = q.leg_s[2];
    status_word[STAT_EN2]  = q.leg_s[3];
    status_word[STAT_BUSY] = (q.leg_s[0] & ~q.leg_s[1]) | (q.leg_s[2] & ~q.leg_s[3]);
  end

  always_comb begin
    d       = q;
    d.leg_m = {leg2.en, leg2.on, leg1.en, leg1.on};
    d.leg_s = q.leg_m;
    if (aw_hs) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (aw_now && w_now && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      if ({wr_addr[ADDR_W-1:2], 2'h0} == CTRL_OFS) begin
        d.bresp = RESP_OKAY;
        if (wr_strb[0]) begin
          d.ctrl = wr_data[CTRL_W-1:0];
        end
      end else if ({wr_addr[ADDR_W-1:2], 2'h0} == STATUS_OFS) begin
        d.bresp = RESP_OKAY;
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
      if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == CTRL_OFS) begin
        d.rdata[CTRL_W-1:0] = q.ctrl;
      end else if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == STATUS_OFS) begin
        d.rdata = status_word;
      end else begin
        d.rresp = RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (!aresetn) begin
      d.ctrl   = CTRL_RESET;
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b0;
      d.bresp  = RESP_OKAY;
      d.rvalid = 1'b0;
      d.rresp  = RESP_OKAY;
      d.rdata  = '0;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  sleep_outputs_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !sleep_n |-> q1 && q1_n && q2 && q2_n)
    else $error("sleep did not pull all outputs high");

  gate_level_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sleep_n && gate_n |-> q1 == level && q1_n == !level && q2 == level)
    else $error("gated outputs not at disable level");

  fanout_pairs_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q1 == q2 && q1_n == q2_n && (!sleep_n || q1_n == !q1))
    else $error("output pairs differ");

  no_overlap_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(leg1.gate && leg2.gate))
    else $error("both sources gated onto outputs");

  toggle_path_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sleep_n && !gate_n |-> q1 == mux_clk)
    else $error("enabled output does not follow selected clock");

  write_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aw_now && w_now && !q.bvalid |=> s_axi_bvalid)
    else $error("write not answered next cycle");

  route_sel_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(q.ctrl[CTRL_SEL]) && sleep_n |-> leg1.want && !leg2.want)
    else $error("select high did not request input one");

  read_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");

  bresp_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  rdata_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped before rready");

  busy_refuse_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");

  unmapped_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    aw_now && w_now && !q.bvalid && {wr_addr[ADDR_W-1:2], 2'h0} != CTRL_OFS &&
      {wr_addr[ADDR_W-1:2], 2'h0} != STATUS_OFS |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  ctrl_reset_a: assert property (
    @(posedge aclk)
    !aresetn |=> q.ctrl == CTRL_RESET)
    else $error("control word not at reset value");

  sleep_wants_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !sleep_n |-> !leg1.want && !leg2.want)
    else $error("sleep left a source requested");

  level_high_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sleep_n && gate_n && level |-> q1 && !q1_n && q2 && !q2_n)
    else $error("high disable level not driven");

  level_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sleep_n && gate_n && !level |-> !q1 && q1_n && !q2 && q2_n)
    else $error("low disable level not driven");

  forced_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.ctrl[CTRL_FORCE] && !leg1.want |-> !leg1.gate)
    else $error("forced switch left unwanted source open");

endmodule

`default_nettype wire

/* File: glitchless_clock_mux_fanout_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module glitchless_clock_mux_fanout_bench;
  import clock_mux_pkg::*;
  // longest legal low gap: three old plus three new cycles with sync latency
  localparam realtime MAXLOW = 800;
  logic              aclk = 1'h0;
  logic              aresetn = 1'h0;
  logic              run1 = 1'h1;
  logic              run2 = 1'h1;
  logic              clk_a1, clk_a2, q1, q1_n, q2, q2_n;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [DATA_W-1:0] wd = '0, rdt, d;
  logic              awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [3:0]        ws = 4'hF;
  logic              awr, wrd, bv, arr, rv;
  logic [1:0]        br, rrs, r;
  logic [4:0]        cv = CTRL_RESET;
  int                num_errors = 0;
  int                checked = 0;
  bit                gchk = 1'h0;
  realtime           tf = 0, tr = 0;

  ref_clocks i_ref_clocks (.run1(run1), .run2(run2), .clk_a1(clk_a1), .clk_a2(clk_a2));

  glitchless_clock_mux_fanout i_glitchless_clock_mux_fanout (
    .aclk(aclk), .aresetn(aresetn), .clk_a1(clk_a1), .clk_a2(clk_a2),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .q1(q1), .q1_n(q1_n), .q2(q2), .q2_n(q2_n)
  );

  always #20 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tmo;
    num_errors++;
    $display("BAD %0t timeout", $time);
    test_done();
  endtask

  task automatic ok(input bit c);
    checked++;
    if (!c) begin
      num_errors++;
      $display("BAD %0t mismatch", $time);
    end
  endtask

  // {q1, q1_n, q2, q2_n} for a given source level and control word
  function automatic logic [3:0] exp_q(input logic c, input logic [4:0] v);
    logic t;
    if (!v[CTRL_SLEEP_N]) return 4'hF;
    t = v[CTRL_GATE_N] ? v[CTRL_LEVEL] : c;
    return {t, ~t, t, ~t};
  endfunction

  always @(q1) begin
    if (q1 === 1'h1) begin
      tr = $realtime;
      if (gchk) ok(tr - tf <= MAXLOW && tr - tf >= 20);
    end else begin
      tf = $realtime;
      if (gchk) ok(tf - tr >= 20);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    int n;
    @(posedge aclk);
    awa <= a;
    wd  <= v;
    awv <= 1'h1;
    wv  <= 1'h1;
    bry <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      if (bv) break;
    end
    if (n == 64) tmo();
    r = br;
    bry <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
      if (rv) break;
    end
    if (n == 64) tmo();
    r = rrs;
    d = rdt;
    rry <= 1'h0;
  endtask

  task automatic ctl(input logic [4:0] v);
    wr(CTRL_OFS, {27'h0, v});
    cv = v;
    ok(r === RESP_OKAY);
  endtask

  task automatic ed(input logic one, input logic rise);
    if (one && rise) @(posedge clk_a1);
    else if (one) @(negedge clk_a1);
    else if (rise) @(posedge clk_a2);
    else @(negedge clk_a2);
    #2;
  endtask

  task automatic fol(input logic one, input int k);
    repeat (k) begin
      ed(one, 1'h1);
      ok({q1, q1_n, q2, q2_n} === exp_q(1'h1, cv));
      ed(one, 1'h0);
      ok({q1, q1_n, q2, q2_n} === exp_q(1'h0, cv));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    tmo();
  end

  initial begin
    void'($urandom(32'hE56AD75C));
    // reset is long enough for each leg to see three of its own edges
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL_OFS);
    ok(r === RESP_OKAY && d === {27'h0, CTRL_RESET});
    #1000;
    fol(1'h1, 4);
    rd(STATUS_OFS);
    ok(d[4:0] === 5'h03);
    wr(8'h0C, '1);
    ok(r === RESP_SLVERR);
    wr(STATUS_OFS, '1);
    ok(r === RESP_OKAY);
    // a write with byte lane zero off must leave control alone
    ws <= 4'h0;
    wr(CTRL_OFS, '0);
    ok(r === RESP_OKAY);
    ws <= 4'hF;
    rd(CTRL_OFS);
    ok(d === {27'h0, cv});
    rd(8'h08);
    ok(r === RESP_SLVERR && d === 32'h0);
    gchk = 1'h1;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      d[4:0] = (d[4:0] & 5'h09) | 5'h10;
      if (i < 2) d[CTRL_SEL] = i[0];
      repeat ($urandom_range(0, 5)) @(posedge aclk);
      wr(CTRL_OFS, d);
      cv = d[4:0];
      ok(r === RESP_OKAY);
      #1200;
      fol(d[CTRL_SEL], 3);
    end
    gchk = 1'h0;
    ctl(5'h11);
    #1200;
    for (int lv = 0; lv < 2; lv++) begin
      ctl({1'h1, lv[0], 3'h5});
      fol(1'h1, 2);
    end
    ctl(5'h05);
    fol(1'h1, 2);
    ctl(5'h15);
    #1200;
    ctl(5'h11);
    fol(1'h1, 3);
    // absent old source one needs the forced switch to hand over to source two
    @(posedge aclk);
    run1 <= 1'h0;
    ctl(5'h12);
    #600;
    fol(1'h0, 3);
    @(posedge aclk);
    run1 <= 1'h1;
    #1000;
    ctl(5'h10);
    #200;
    fol(1'h0, 3);
    test_done();
  end
endmodule

`default_nettype wire

/* File: ref_clocks.sv */
`timescale 1ns/10ps
`default_nettype none

// two free-running references; a stopped one sits low like an absent source
module ref_clocks (
  input  wire logic run1,
  input  wire logic run2,
  output logic      clk_a1,
  output logic      clk_a2
);
  initial begin
    clk_a1 = 1'h0;
    #13;
    forever #40 clk_a1 = run1 ? ~clk_a1 : 1'h0;
  end
  initial begin
    clk_a2 = 1'h0;
    #7;
    forever #26 clk_a2 = run2 ? ~clk_a2 : 1'h0;
  end
endmodule

`default_nettype wire
